// ===== sdimb_ctrl.sv
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module sdimb_ctrl (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Avalon-MM slave
   input wire logic [sdimb_pkg::AV_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [sdimb_pkg::BUS_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [sdimb_pkg::BUS_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Memory link
   sdimb_if.ctrl link
);
   import sdimb_pkg::*;

   typedef enum logic [3:0] {
      ST_OFF, ST_POWER, ST_PRE, ST_REF, ST_LOAD, ST_EXT, ST_READY, ST_GAP
   } sdimb_state_t;

   sdimb_state_t state;
   sdimb_state_t ret;
   logic [WAIT_W-1:0] wait_cnt;
   logic [1:0] ref_left;
   logic [RD_CNT_W-1:0] rd_cnt;
   logic [MODE_W-1:0] mode_cfg;
   logic [MODE_W-1:0] ext_cfg;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic rdata_valid;
   logic init_done;
   logic busy;
   logic [CMD_W-1:0] cmd_q;
   logic sel_ctrl;
   logic sel_mode;
   logic sel_ext;
   logic sel_cmd;
   logic sel_wdata;
   logic sel_rdata;
   logic wr_en;
   logic start;
   logic user_go;
   logic [OP_W-1:0] user_op;
   logic issue_rd;
   logic capture;
   logic [BUS_W-1:0] status_word;

   // Register decode
   assign sel_ctrl = (avs_address == REG_CTRL);
   assign sel_mode = (avs_address == REG_MODE);
   assign sel_ext = (avs_address == REG_EXT);
   assign sel_cmd = (avs_address == REG_CMD);
   assign sel_wdata = (avs_address == REG_WDATA);
   assign sel_rdata = (avs_address == REG_RDATA);
   assign busy = (state != ST_READY);
   assign avs_waitrequest = (avs_read || avs_write) &&
                            (!ce || (avs_write && sel_cmd && init_done && busy));
   assign wr_en = avs_write && (|avs_byteenable) && !avs_waitrequest;
   assign start = wr_en && sel_ctrl && avs_writedata[CTRL_START_BIT];
   assign user_go = wr_en && sel_cmd && init_done && !busy;
   assign user_op = avs_writedata[CMD_OP_LSB +: OP_W];
   assign issue_rd = user_go && (user_op == OP_RD);
   assign capture = (rd_cnt == RD_CNT_W'(1));

   // Read data selection
   assign status_word = BUS_W'({rdata_valid, busy, init_done});
   assign avs_readdata = sel_ctrl ? status_word :
                         sel_mode ? BUS_W'(mode_cfg) :
                         sel_ext ? BUS_W'(ext_cfg) :
                         sel_wdata ? BUS_W'(wdata) :
                         sel_rdata ? BUS_W'(rdata) : '0;

   // Configuration registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_cfg <= MODE_RESET;
         ext_cfg <= EXT_DEFAULT;
         wdata <= '0;
      end else if (ce && wr_en) begin
         if (sel_mode) mode_cfg <= avs_writedata[MODE_W-1:0] & MODE_NORMAL_MASK;
         if (sel_ext) ext_cfg <= avs_writedata[MODE_W-1:0];
         if (sel_wdata) wdata <= avs_writedata[DATA_W-1:0];
      end
   end

   // Read capture at the programmed latency
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rd_cnt <= '0;
         rdata <= '0;
         rdata_valid <= 1'b0;
      end else if (ce) begin
         if (issue_rd) begin
            rd_cnt <= RD_CNT_W'(mode_cfg[RL_LSB +: RL_W]) + RD_CNT_W'(1);
         end else if (rd_cnt != '0) begin
            rd_cnt <= rd_cnt - RD_CNT_W'(1);
         end
         if (capture) rdata <= link.dq;
         // Capture wins over clear
         if (capture) rdata_valid <= 1'b1;
         else if (user_go) rdata_valid <= 1'b0;
      end
   end

   assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_q;

   // Power-up sequence and command issue
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= ST_OFF;
         ret <= ST_OFF;
         wait_cnt <= '0;
         ref_left <= '0;
         init_done <= 1'b0;
         link.cke <= 1'b0;
         cmd_q <= CMD_INHIBIT;
         link.ba <= '0;
         link.addr <= '0;
         link.ctrl_dq <= '0;
         link.ctrl_dq_oe <= 1'b0;
      end else if (ce) begin
         if (start) begin
            state <= ST_POWER;
            init_done <= 1'b0;
            link.cke <= 1'b0;
            cmd_q <= CMD_INHIBIT;
            wait_cnt <= WAIT_W'(POWER_WAIT_CYC - 1);
         end else begin
            case (state)
               ST_OFF: begin
                  cmd_q <= CMD_INHIBIT;
               end
               ST_POWER: begin
                  cmd_q <= link.cke ? CMD_NOP : CMD_INHIBIT;
                  if (wait_cnt <= WAIT_W'(CKE_RAISE_CYC)) link.cke <= 1'b1;
                  if (wait_cnt == '0) state <= ST_PRE;
                  else wait_cnt <= wait_cnt - WAIT_W'(1);
               end
               ST_PRE: begin
                  cmd_q <= CMD_PRE;
                  link.addr <= ALL_BANKS_ADDR;
                  wait_cnt <= WAIT_W'(PRECHARGE_WAIT_CYC - 1);
                  ref_left <= 2'(REFRESH_COUNT);
                  ret <= ST_REF;
                  state <= ST_GAP;
               end
               ST_REF: begin
                  cmd_q <= CMD_REF;
                  wait_cnt <= WAIT_W'(REFRESH_WAIT_CYC - 1);
                  ref_left <= ref_left - 2'(1);
                  ret <= (ref_left == 2'(1)) ? ST_LOAD : ST_REF;
                  state <= ST_GAP;
               end
               ST_LOAD: begin
                  cmd_q <= CMD_LOAD;
                  link.ba <= BA_BASE;
                  link.addr <= mode_cfg;
                  wait_cnt <= WAIT_W'(SETUP_LOAD_WAIT_CYC - 1);
                  ret <= ST_EXT;
                  state <= ST_GAP;
               end
               ST_EXT: begin
                  cmd_q <= CMD_LOAD;
                  link.ba <= BA_EXT;
                  link.addr <= ext_cfg;
                  wait_cnt <= WAIT_W'(SETUP_LOAD_WAIT_CYC - 1);
                  ret <= ST_READY;
                  state <= ST_GAP;
               end
               ST_READY: begin
                  init_done <= 1'b1;
                  if (user_go) begin
                     cmd_q <= (user_op == OP_ACT) ? CMD_ACT :
                              (user_op == OP_RD) ? CMD_RD :
                              (user_op == OP_WR) ? CMD_WR :
                              (user_op == OP_PRE) ? CMD_PRE :
                              (user_op == OP_REF) ? CMD_REF :
                              (user_op == OP_BST) ? CMD_BST : CMD_NOP;
                     link.ba <= avs_writedata[CMD_BA_LSB +: BANK_W];
                     link.addr <= avs_writedata[CMD_ADDR_LSB +: ROW_W];
                     link.ctrl_dq <= wdata;
                     link.ctrl_dq_oe <= (user_op == OP_WR);
                     wait_cnt <= WAIT_W'(USER_GAP_CYC - 1);
                     ret <= ST_READY;
                     state <= ST_GAP;
                  end
               end
               ST_GAP: begin
                  cmd_q <= CMD_NOP;
                  link.ctrl_dq_oe <= 1'b0;
                  if (wait_cnt == '0) state <= ret;
                  else wait_cnt <= wait_cnt - WAIT_W'(1);
               end
               default: state <= ST_OFF;
            endcase
         end
      end
   end
endmodule : sdimb_ctrl

// ===== sdimb_pkg.sv
package sdimb_pkg;
   // Array geometry, x16 variant
   localparam int NUM_BANKS = 4;
   localparam int ROWS_PER_BANK = 4096;
   localparam int COLS_PER_ROW = 512;
   localparam int BANK_W = $clog2(NUM_BANKS);
   localparam int ROW_W = $clog2(ROWS_PER_BANK);
   localparam int COL_W = $clog2(COLS_PER_ROW);
   localparam int DATA_W = 16;
   localparam int MODE_W = 12;

   // Link command codes {cs_n, ras_n, cas_n, we_n}
   localparam int CMD_W = 4;
   localparam logic [CMD_W-1:0] CMD_INHIBIT = 4'hF;
   localparam logic [CMD_W-1:0] CMD_NOP = 4'h7;
   localparam logic [CMD_W-1:0] CMD_ACT = 4'h3;
   localparam logic [CMD_W-1:0] CMD_RD = 4'h5;
   localparam logic [CMD_W-1:0] CMD_WR = 4'h4;
   localparam logic [CMD_W-1:0] CMD_BST = 4'h6;
   localparam logic [CMD_W-1:0] CMD_PRE = 4'h2;
   localparam logic [CMD_W-1:0] CMD_REF = 4'h1;
   localparam logic [CMD_W-1:0] CMD_LOAD = 4'h0;

   // Setup word fields
   localparam int BL_LSB = 0;
   localparam int BL_W = 3;
   localparam int ORDER_BIT = 3;
   localparam int RL_LSB = 4;
   localparam int RL_W = 3;
   localparam int SINGLE_WRITE_BIT = 9;
   localparam int AUTO_PRE_BIT = 10;
   localparam logic [BL_W-1:0] BL_CODE_8 = 3'h3;
   localparam logic [BL_W-1:0] BL_CODE_FULL = 3'h7;
   localparam logic [RL_W-1:0] RL_2 = 3'h2;
   localparam logic [RL_W-1:0] RL_3 = 3'h3;
   localparam logic [BANK_W-1:0] BA_BASE = 2'h0;
   localparam logic [BANK_W-1:0] BA_EXT = 2'h2;
   localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
   localparam logic [MODE_W-1:0] EXT_DEFAULT = 12'h000;
   localparam logic [MODE_W-1:0] MODE_NORMAL_MASK = 12'h27F;
   localparam logic [ROW_W-1:0] ALL_BANKS_ADDR = 12'h400;

   // Device read pipeline and storage
   localparam int RL_STAGES = 3;
   localparam int MEM_ROW_W = 1;
   localparam int MEM_COL_W = 3;
   localparam int MEM_IDX_W = BANK_W + MEM_ROW_W + MEM_COL_W;
   localparam int MEM_DEPTH = 1 << MEM_IDX_W;

   // Timing
   localparam int CLK_MHZ = 25;
   localparam int POWER_WAIT_US = 100;
   localparam int PRECHARGE_WAIT_NS = 19;
   localparam int REFRESH_WAIT_NS = 80;
   localparam int SETUP_LOAD_WAIT_CYC = 2;
   localparam int POWER_WAIT_CYC = POWER_WAIT_US * CLK_MHZ;
   localparam int PRE_RAW = (PRECHARGE_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int PRECHARGE_WAIT_CYC = (PRE_RAW < 1) ? 1 : PRE_RAW;
   localparam int REF_RAW = (REFRESH_WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int REFRESH_WAIT_CYC = (REF_RAW < 1) ? 1 : REF_RAW;
   localparam int CKE_RAISE_CYC = POWER_WAIT_CYC / 2;
   localparam int REFRESH_COUNT = 2;
   localparam int USER_GAP_CYC = RL_STAGES + 2;
   localparam int WAIT_W = 12;
   localparam int RD_CNT_W = 4;

   // Register map of the controller
   localparam int AV_ADDR_W = 8;
   localparam int BUS_W = 32;
   localparam int OP_W = 3;
   localparam logic [AV_ADDR_W-1:0] REG_CTRL = 8'h00;
   localparam logic [AV_ADDR_W-1:0] REG_MODE = 8'h04;
   localparam logic [AV_ADDR_W-1:0] REG_EXT = 8'h08;
   localparam logic [AV_ADDR_W-1:0] REG_CMD = 8'h0C;
   localparam logic [AV_ADDR_W-1:0] REG_WDATA = 8'h10;
   localparam logic [AV_ADDR_W-1:0] REG_RDATA = 8'h14;
   localparam int CTRL_START_BIT = 0;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BA_LSB = 4;
   localparam int CMD_ADDR_LSB = 16;
   localparam logic [OP_W-1:0] OP_ACT = 3'h0;
   localparam logic [OP_W-1:0] OP_RD = 3'h1;
   localparam logic [OP_W-1:0] OP_WR = 3'h2;
   localparam logic [OP_W-1:0] OP_PRE = 3'h3;
   localparam logic [OP_W-1:0] OP_REF = 3'h4;
   localparam logic [OP_W-1:0] OP_BST = 3'h5;
endpackage : sdimb_pkg

// ===== sdimb_if.sv
`timescale 1ns/1ps
interface sdimb_if;
   import sdimb_pkg::*;
   // Command and address pins
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [BANK_W-1:0] ba;
   logic [ROW_W-1:0] addr;
   // Data pins, split per driver
   logic [DATA_W-1:0] ctrl_dq;
   logic ctrl_dq_oe;
   logic [DATA_W-1:0] dev_dq;
   logic dev_dq_oe;
   logic [DATA_W-1:0] dq;

   // Wire level, device wins while it drives
   assign dq = dev_dq_oe ? dev_dq : ctrl_dq;

   modport ctrl (
      output cke, cs_n, ras_n, cas_n, we_n, ba, addr, ctrl_dq, ctrl_dq_oe,
      input dq
   );
   modport dev (
      input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq,
      output dev_dq, dev_dq_oe
   );
endinterface : sdimb_if

// ===== sdimb_burst_addr.sv
`timescale 1ns/1ps
module sdimb_burst_addr (
   // Burst description
   input wire logic [sdimb_pkg::COL_W-1:0] start_col,
   input wire logic [sdimb_pkg::COL_W-1:0] beat_idx,
   input wire logic [sdimb_pkg::COL_W-1:0] len_m1,
   input wire logic interleave,
   // Column of this beat
   output logic [sdimb_pkg::COL_W-1:0] col
);
   import sdimb_pkg::*;

   logic [COL_W-1:0] seq_col;
   logic [COL_W-1:0] int_col;
   logic [COL_W-1:0] inner;

   // Order within the block
   assign seq_col = start_col + beat_idx;
   assign int_col = start_col ^ beat_idx;
   assign inner = interleave ? int_col : seq_col;
   assign col = (start_col & ~len_m1) | (inner & len_m1);
endmodule : sdimb_burst_addr

// ===== sdimb_device.sv
`timescale 1ns/1ps
module sdimb_device (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Memory link
   sdimb_if.dev link,
   // Status to user side
   output logic [sdimb_pkg::MODE_W-1:0] mode_word,
   output logic [sdimb_pkg::MODE_W-1:0] ext_mode_word,
   output logic mode_loaded,
   output logic banks_idle
);
   import sdimb_pkg::*;

   logic ce;
   logic [CMD_W-1:0] cmd;
   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_rw;
   logic is_bst;
   logic is_pre;
   logic is_load;
   logic [NUM_BANKS-1:0] bank_open;
   logic [ROW_W-1:0] open_row [NUM_BANKS];
   logic [BL_W-1:0] bl_code;
   logic [RL_W-1:0] rl_code;
   logic order_bit;
   logic single_write;
   logic new_full;
   logic [COL_W-1:0] new_len;
   logic burst_on;
   logic burst_wr;
   logic burst_inter;
   logic burst_full;
   logic [COL_W-1:0] burst_idx;
   logic [COL_W-1:0] burst_start;
   logic [COL_W-1:0] burst_len;
   logic [BANK_W-1:0] burst_bank;
   logic beat;
   logic cur_wr;
   logic cur_inter;
   logic [COL_W-1:0] cur_start;
   logic [COL_W-1:0] cur_idx;
   logic [COL_W-1:0] cur_len;
   logic [COL_W-1:0] cur_col;
   logic [BANK_W-1:0] cur_bank;
   logic [ROW_W-1:0] cur_row;
   logic [MEM_IDX_W-1:0] mem_idx;
   logic [DATA_W-1:0] mem [MEM_DEPTH];
   logic [DATA_W-1:0] mem_q;
   logic rd_beat;
   logic [RL_STAGES-1:0] pipe_v;
   logic [RL_STAGES-1:0][DATA_W-1:0] pipe_d;
   logic [RL_STAGES-1:0] chain_v;
   logic [RL_STAGES-1:0][DATA_W-1:0] chain_d;
   logic [1:0] rl_sel;

   // Burst length minus one from the length code
   function automatic logic [COL_W-1:0] len_m1_of(
      input logic [BL_W-1:0] code
   );
      if (code == BL_CODE_FULL) begin
         len_m1_of = '1;
      end else if (code <= BL_CODE_8) begin
         len_m1_of = COL_W'((1 << code) - 1);
      end else begin
         len_m1_of = '0;
      end
   endfunction : len_m1_of

   assign ce = link.cke;
   assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};

   // Command decode; inhibit matches nothing
   assign is_act = (cmd == CMD_ACT);
   assign is_rd = (cmd == CMD_RD) && bank_open[link.ba];
   assign is_wr = (cmd == CMD_WR) && bank_open[link.ba];
   assign is_rw = is_rd || is_wr;
   assign is_bst = (cmd == CMD_BST);
   assign is_pre = (cmd == CMD_PRE);
   assign is_load = (cmd == CMD_LOAD);

   assign bl_code = mode_word[BL_LSB +: BL_W];
   assign rl_code = mode_word[RL_LSB +: RL_W];
   assign order_bit = mode_word[ORDER_BIT];
   assign single_write = mode_word[SINGLE_WRITE_BIT];

   assign new_len = (is_wr && single_write) ? '0 : len_m1_of(bl_code);
   assign new_full = (bl_code == BL_CODE_FULL) && !(is_wr && single_write);

   // Open row and idle state per bank
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      always_ff @(posedge clk) begin
         if (!rstn) begin
            bank_open[b] <= 1'b0;
            open_row[b] <= '0;
         end else if (ce) begin
            if (is_act && link.ba == BANK_W'(b)) begin
               bank_open[b] <= 1'b1;
               open_row[b] <= link.addr;
            end else if (is_pre && (link.addr[AUTO_PRE_BIT] ||
                                    link.ba == BANK_W'(b))) begin
               bank_open[b] <= 1'b0;
            end
         end
      end
   end

   assign banks_idle = ~|bank_open;

   // Setup word registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mode_word <= MODE_RESET;
         ext_mode_word <= EXT_DEFAULT;
         mode_loaded <= 1'b0;
      end else if (ce && is_load) begin
         if (link.ba == BA_BASE) begin
            mode_word <= link.addr;
            mode_loaded <= 1'b1;
         end else if (link.ba == BA_EXT) begin
            ext_mode_word <= link.addr;
         end
      end
   end

   // burst state after read or write
   always_ff @(posedge clk) begin
      if (!rstn) begin
         burst_on <= 1'b0;
         burst_wr <= 1'b0;
         burst_inter <= 1'b0;
         burst_full <= 1'b0;
         burst_idx <= '0;
         burst_start <= '0;
         burst_len <= '0;
         burst_bank <= '0;
      end else if (ce) begin
         if (is_rw) begin
            burst_on <= (new_len != '0);
            burst_wr <= is_wr;
            burst_inter <= cur_inter;
            burst_full <= new_full;
            burst_idx <= COL_W'(1);
            burst_start <= link.addr[COL_W-1:0];
            burst_len <= new_len;
            burst_bank <= link.ba;
         end else if (is_bst || is_pre || is_load) begin
            burst_on <= 1'b0;
         end else if (burst_on) begin
            burst_idx <= burst_idx + COL_W'(1);
            if (burst_idx == burst_len && !burst_full) begin
               burst_on <= 1'b0;
            end
         end
      end
   end

   // Beat of this cycle, the command edge itself first
   assign beat = is_rw || burst_on;
   assign cur_wr = is_rw ? is_wr : burst_wr;
   assign cur_inter = is_rw ? (order_bit && !new_full) : burst_inter;
   assign cur_start = is_rw ? link.addr[COL_W-1:0] : burst_start;
   assign cur_idx = is_rw ? '0 : burst_idx;
   assign cur_len = is_rw ? new_len : burst_len;
   assign cur_bank = is_rw ? link.ba : burst_bank;
   assign cur_row = open_row[cur_bank];

   sdimb_burst_addr u_col (
      .start_col(cur_start),
      .beat_idx(cur_idx),
      .len_m1(cur_len),
      .interleave(cur_inter),
      .col(cur_col)
   );

   // storage index from bank, row and column
   assign mem_idx = {cur_bank, cur_row[MEM_ROW_W-1:0],
                     cur_col[MEM_COL_W-1:0]};
   assign mem_q = mem[mem_idx];

   // Write beats store the bus word
   always_ff @(posedge clk) begin
      if (ce && beat && cur_wr) begin
         mem[mem_idx] <= link.dq;
      end
   end

   // Read pipeline, one stage per latency clock
   assign rd_beat = beat && !cur_wr;
   assign chain_v = {pipe_v[RL_STAGES-2:0], rd_beat};
   assign chain_d = {pipe_d[RL_STAGES-2:0], mem_q};

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pipe_v <= '0;
         pipe_d <= '0;
      end else if (ce) begin
         pipe_v <= is_load ? '0 : chain_v;
         pipe_d <= chain_d;
      end
   end

   assign rl_sel = (rl_code == RL_3) ? 2'h2 : (rl_code == RL_2) ? 2'h1 : 2'h0;
   assign link.dev_dq = pipe_d[rl_sel];
   assign link.dev_dq_oe = pipe_v[rl_sel];
endmodule : sdimb_device

// ===== sdimb_checker.sv
`timescale 1ns/1ps
module sdimb_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link pins
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [sdimb_pkg::BANK_W-1:0] ba,
   input wire logic [sdimb_pkg::ROW_W-1:0] addr,
   input wire logic ctrl_dq_oe,
   input wire logic dev_dq_oe
);
   import sdimb_pkg::*;
   logic [2:0] cl;
   logic [2:0] bl;
   logic [3:0] opn;
   logic [1:0] nref;
   logic [3:0] run;
   logic [11:0] up;
   wire [3:0] cmd;
   wire quiet;
   // Command decode
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign quiet = (cmd == CMD_NOP) || (cmd == CMD_INHIBIT);
   // Latency and length codes of the last base load
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cl <= 3'h0;
         bl <= 3'h0;
      end else if (cmd == CMD_LOAD && ba == BA_BASE) begin
         cl <= addr[6:4];
         bl <= addr[BL_LSB +: BL_W];
      end
   end
   // Open banks, refreshes since the last precharge-all
   always_ff @(posedge clk) begin
      if (!rstn) begin
         opn <= 4'h0;
         nref <= 2'h0;
      end else if (cke && cmd == CMD_ACT) begin
         opn[ba] <= 1'b1;
      end else if (cke && cmd == CMD_PRE) begin
         if (addr[AUTO_PRE_BIT]) begin
            opn <= 4'h0;
            nref <= 2'h0;
         end else begin
            opn[ba] <= 1'b0;
         end
      end else if (cke && cmd == CMD_REF && nref != 2'h3) begin
         nref <= nref + 2'h1;
      end
   end
   // Length of the current run of driven read beats
   always_ff @(posedge clk) begin
      if (!rstn || !dev_dq_oe) run <= 4'h0;
      else if (run != 4'hF) run <= run + 4'h1;
   end
   // Cycles since the clock gate rose
   always_ff @(posedge clk) begin
      if (!cke) up <= 12'h000;
      else if (up != 12'hFFF) up <= up + 12'h001;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_gate_low_inhibit: assert property (!cke |-> cmd == CMD_INHIBIT)
      else $error("command while clock gate low");
   a_power_wait: assert property (!quiet |-> up >= 12'd1248)
      else $error("command before power-up wait");
   a_cmd_pulse: assert property (!quiet |=> cmd == CMD_NOP)
      else $error("command not followed by no-op");
   a_load_bank: assert property (cmd == CMD_LOAD |-> ba[0] == 1'b0)
      else $error("load to unknown register");
   a_load_normal: assert property (cmd == CMD_LOAD && ba == BA_BASE
      |-> (addr & ~MODE_NORMAL_MASK) == 12'h000)
      else $error("setup word not in normal mode");
   a_load_release: assert property (cmd == CMD_LOAD |=> !dev_dq_oe [*2])
      else $error("data driven after load");
   a_read_lat1: assert property (cmd == CMD_RD && cl == 3'h1
      |=> dev_dq_oe)
      else $error("latency one wrong");
   a_read_lat2: assert property (cmd == CMD_RD && cl == 3'h2
      |=> !dev_dq_oe ##1 dev_dq_oe)
      else $error("latency two wrong");
   a_read_lat3: assert property (cmd == CMD_RD && cl == 3'h3
      |=> !dev_dq_oe [*2] ##1 dev_dq_oe)
      else $error("latency three wrong");
   a_write_drive: assert property (ctrl_dq_oe |-> cmd == CMD_WR)
      else $error("data driven outside write");
   a_load_wait: assert property (cmd == CMD_LOAD |=> quiet [*2])
      else $error("command inside setup-load wait");
   a_load_idle: assert property (cmd == CMD_LOAD |-> opn == 4'h0)
      else $error("setup load with a bank open");
   a_two_refresh: assert property (cmd == CMD_LOAD |-> nref >= 2'h2)
      else $error("setup load before two refreshes");
   a_burst_beats: assert property ($fell(dev_dq_oe) && bl <= BL_CODE_8
      |-> run == (4'h1 << bl))
      else $error("read burst length wrong");
endmodule : sdimb_checker

// ===== sdram_init_mode_burst_bench.sv
`timescale 1ns/1ps
module sdram_init_mode_burst_bench;
   import sdimb_pkg::*;
   logic clk = 0, rstn = 0, ce = 1, rd = 0, wr = 0, wt, loaded, idle;
   logic [7:0] adr = 8'h00;
   logic [3:0] be = 4'hF;
   logic [31:0] wd = 32'h0, q, rdat;
   logic [11:0] mword, eword;
   int seed = 30, miscompares = 0, n_tests = 0;
   sdimb_if lnk();
   // Clock
   always #20 clk = ~clk;
   sdimb_ctrl u_sdimb_ctrl (.clk(clk), .rstn(rstn), .ce(ce),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wt), .link(lnk.ctrl));
   sdimb_device u_sdimb_device (.clk(clk), .rstn(rstn), .link(lnk.dev),
      .mode_word(mword), .ext_mode_word(eword), .mode_loaded(loaded),
      .banks_idle(idle));
   sdimb_checker u_sdimb_checker (.clk(clk), .rstn(rstn), .cke(lnk.cke),
      .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n),
      .we_n(lnk.we_n), .ba(lnk.ba), .addr(lnk.addr),
      .ctrl_dq_oe(lnk.ctrl_dq_oe), .dev_dq_oe(lnk.dev_dq_oe));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   // One bus cycle, held until waitrequest is low
   task av(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wt) begin
         i++;
         if (i > 50) begin
            miscompares++;
            test_done;
         end
         @(posedge clk);
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask : av
   // Poll a status bit with a bound
   task poll(input int n, input int lim);
      int i;
      i = 0;
      do begin
         av(1'b0, REG_CTRL, 32'h0);
         i++;
      end while (!q[n] && i < lim);
      if (!q[n]) begin
         miscompares++;
         test_done;
      end
   endtask : poll
   // Main sequence
   initial begin
      logic [11:0] m, ew, r;
      logic [1:0] b;
      logic [8:0] c;
      logic [15:0] d;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk(eword, EXT_DEFAULT);
      chk(loaded, 1'b0);
      av(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      av(1'b0, REG_CMD, 32'h0);
      chk(q, 32'h0);
      for (int k = 1; k <= 3; k++) begin
         m = {2'h3, 1'($random(seed)), 2'h3, 3'(k), 1'($random(seed)), 3'(k)};
         ew = 12'($random(seed));
         av(1'b1, REG_MODE, m);
         av(1'b1, REG_EXT, ew);
         // Write with no byte lane set is ignored
         be <= 4'h0;
         av(1'b1, REG_MODE, 32'hFFF);
         be <= 4'hF;
         av(1'b0, REG_MODE, 32'h0);
         chk(q, m & MODE_NORMAL_MASK);
         av(1'b1, REG_CTRL, 32'h1);
         // Enable low stalls the bus and freezes the sequence
         ce <= 1'b0;
         rd <= 1'b1;
         adr <= REG_CTRL;
         repeat (3) @(posedge clk);
         chk(wt, 1'b1);
         ce <= 1'b1;
         @(posedge clk);
         chk(rdat, 32'h2);
         rd <= 1'b0;
         @(posedge clk);
         poll(0, 2000);
         chk(mword, m & MODE_NORMAL_MASK);
         chk(eword, ew);
         chk({loaded, idle}, 2'h3);
         for (int j = 0; j < 4; j++) begin
            b = (j == 0) ? 2'h3 : 2'($random(seed));
            r = (j == 0) ? 12'hFFF : 12'($random(seed));
            c = (j == 0) ? 9'h1FF : 9'($random(seed));
            d = 16'($random(seed));
            av(1'b1, REG_CMD, {4'h0, r, 10'h0, b, 1'b0, OP_ACT});
            av(1'b1, REG_WDATA, {16'h0, d});
            av(1'b1, REG_CMD, {7'h0, c, 10'h0, b, 1'b0, OP_WR});
            av(1'b1, REG_CMD, {7'h0, c, 10'h0, b, 1'b0, OP_RD});
            poll(2, 20);
            av(1'b0, REG_RDATA, 32'h0);
            chk(q, {16'h0, d});
            av(1'b1, REG_CMD, {29'h0, OP_PRE});
         end
         $display("latency %0d test done", k);
      end
      test_done;
   end
endmodule : sdram_init_mode_burst_bench
